// *** tb/windowed_watchdog_timer_tb.sv ***
`timescale 1ns/100ps
module windowed_watchdog_timer_tb;
  import wwd_pkg::*;
  logic       ref_clk, reset, dbg_mode, reg_wr, reg_rd, nmi, prewarn, sys_reset_req, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q, rl, e;
  int         err_total, check_count, seed, cyc, w;
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  wwd_cpu i_wwd_cpu (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  wwd_top i_wwd_top (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dbg_mode(dbg_mode), .nmi(nmi), .prewarn(prewarn), .sys_reset_req(sys_reset_req),
    .irq(irq));
  function automatic logic [7:0] exp_low(input int c, input int d);
    return 8'(c / d);
  endfunction
  task automatic print_verdict();
    if (err_total == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    check_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t byte %h not in %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic rst();
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
  endtask
  // settle two edges so registered outputs have landed
  task automatic tick2();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  // hang guard, ample for the longest trip and prewarning phase
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    seed = 72;
    err_total = 0;
    check_count = 0;
    cyc = 0;
    reset = 1'b1;
    dbg_mode = 1'b0;
    rst();
    i_wwd_cpu.rd(WWD_ADDR_CNT_LO, q);
    chk(q, 8'h00, 8'h00);
    i_wwd_cpu.rd(WWD_ADDR_CNT_HI, q);
    chk(q, 8'h00, 8'h00);
    i_wwd_cpu.rd(8'h00, q);
    chk(q, 8'h00, 8'h00);
    // random reload kept below 80 so a short lap cannot overflow
    rl = 8'($random(seed)) & 8'h7F;
    i_wwd_cpu.wr(WWD_ADDR_RELOAD, rl);
    i_wwd_cpu.wr(WWD_ADDR_CTRL, 8'h01);
    i_wwd_cpu.svc();
    i_wwd_cpu.rd(WWD_ADDR_CNT_HI, q);
    chk(q, rl, rl);
    for (int i = 0; i < 4; i++) begin
      w = (i == 3) ? 384 : 20 + ($unsigned($random(seed)) % 150);
      if (i == 3) i_wwd_cpu.wr(WWD_ADDR_CTRL, 8'h03);
      i_wwd_cpu.svc();
      repeat (w) @(posedge ref_clk);
      e = exp_low(w, (i == 3) ? WWD_DIV_SLOW : WWD_DIV_FAST);
      i_wwd_cpu.rd(WWD_ADDR_CNT_LO, q);
      chk(q, e - 8'h01, e + 8'h02);
    end
    i_wwd_cpu.wr(WWD_ADDR_CTRL, 8'h01);
    i_wwd_cpu.svc();
    repeat (532) @(posedge ref_clk);
    i_wwd_cpu.rd(WWD_ADDR_CNT_HI, q);
    chk(q, rl + 8'h01, rl + 8'h01);
    @(posedge ref_clk);
    dbg_mode <= 1'b1;
    // let the level pass both sync flops before the snapshot, else one late tick slips in
    repeat (4) @(posedge ref_clk);
    i_wwd_cpu.rd(WWD_ADDR_CNT_LO, e);
    repeat (60) @(posedge ref_clk);
    i_wwd_cpu.rd(WWD_ADDR_CNT_LO, q);
    chk(q, e, e);
    // software may keep the count running under debug: about 31 fast ticks
    i_wwd_cpu.wr(WWD_ADDR_CTRL, 8'h09);
    i_wwd_cpu.rd(WWD_ADDR_CNT_LO, e);
    repeat (60) @(posedge ref_clk);
    i_wwd_cpu.rd(WWD_ADDR_CNT_LO, q);
    chk(q, e + 8'h1D, e + 8'h21);
    @(posedge ref_clk);
    dbg_mode <= 1'b0;
    // expiry: reload at top so the trip comes after one low lap
    i_wwd_cpu.wr(WWD_ADDR_MASK, 8'h01);
    i_wwd_cpu.wr(WWD_ADDR_RELOAD, 8'hFF);
    i_wwd_cpu.svc();
    w = 0;
    while (nmi !== 1'b1 && w < 2000) begin
      @(posedge ref_clk);
      #1;
      w++;
    end
    chk_bit(nmi, 1'b1);
    chk_bit(prewarn, 1'b1);
    w = cyc;
    i_wwd_cpu.svc();
    i_wwd_cpu.rd(WWD_ADDR_CNT_HI, q);
    chk(q, 8'h00, 8'h01);
    i_wwd_cpu.rd(WWD_ADDR_STATUS, q);
    chk(q, 8'h01, 8'h01);
    chk_bit(irq, 1'b1);
    i_wwd_cpu.wr(WWD_ADDR_MASK, 8'h00);
    tick2();
    chk_bit(irq, 1'b0);
    i_wwd_cpu.wr(WWD_ADDR_MASK, 8'h01);
    tick2();
    chk_bit(irq, 1'b1);
    i_wwd_cpu.wr(WWD_ADDR_STATUS, 8'h01);
    tick2();
    chk_bit(irq, 1'b0);
    while (sys_reset_req !== 1'b1 && cyc - w < 1200) @(posedge ref_clk);
    #1;
    chk_bit(sys_reset_req, 1'b1);
    chk_bit(cyc - w >= 500, 1'b1);
    rst();
    // a service right at the window boundary is legal and reloads
    i_wwd_cpu.wr(WWD_ADDR_RELOAD, 8'h10);
    i_wwd_cpu.wr(WWD_ADDR_CTRL, 8'h01);
    i_wwd_cpu.svc();
    i_wwd_cpu.wr(WWD_ADDR_WINDOW, 8'h10);
    i_wwd_cpu.wr(WWD_ADDR_CTRL, 8'h05);
    i_wwd_cpu.svc();
    tick2();
    chk_bit(prewarn, 1'b0);
    i_wwd_cpu.rd(WWD_ADDR_CNT_HI, q);
    chk(q, 8'h10, 8'h10);
    // early service inside a closed window trips like an expiry
    i_wwd_cpu.wr(WWD_ADDR_WINDOW, 8'h80);
    i_wwd_cpu.svc();
    tick2();
    chk_bit(prewarn, 1'b1);
    i_wwd_cpu.rd(WWD_ADDR_STATUS, q);
    chk(q, 8'h02, 8'h02);
    print_verdict();
  end
endmodule

// *** tb/wwd_cpu.sv ***
`timescale 1ns/100ps
module wwd_cpu
  import wwd_pkg::*;
(
  // clock
  input  wire logic       ref_clk,
  // register port towards the watchdog
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // idle bus from time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // one-cycle write strobe, the slave never stalls
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  // a service access, one write of 5A to the service register at whatever time the caller chooses
  task automatic svc();
    wr(WWD_ADDR_SVC, 8'h5A);
  endtask
endmodule

// *** tb/wwd_top_asserts.sv ***
`timescale 1ns/100ps
module wwd_top_asserts
  import wwd_pkg::*;
(
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // debug input and system outputs
  input wire logic       dbg_mode,
  input wire logic       nmi,
  input wire logic       prewarn,
  input wire logic       sys_reset_req,
  input wire logic       irq
);
  logic [7:0] reload_r;
  logic       win_r;
  // shadow of reload and window enable, so a plain service can be predicted
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reload_r <= 8'h00;
      win_r    <= 1'b0;
    end else if (reg_wr && reg_addr == WWD_ADDR_RELOAD) begin
      reload_r <= reg_wdata;
    end else if (reg_wr && reg_addr == WWD_ADDR_CTRL) begin
      win_r <= reg_wdata[WWD_CTRL_WIN_EN];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // window checks are left out here, a service may then trip instead
  sequence s_svc;
    reg_wr && reg_addr == WWD_ADDR_SVC && !prewarn && !win_r;
  endsequence
  sequence s_rd_hi;
    reg_rd && reg_addr == WWD_ADDR_CNT_HI;
  endsequence
  a_svc_loads_high: assert property (s_svc ##2 s_rd_hi |=> reg_rdata == reload_r)
    else $error("service did not load high byte");
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  a_nmi_one_cycle: assert property (nmi |=> !nmi)
    else $error("nmi longer than one cycle");
  a_nmi_with_prewarn: assert property (nmi |-> prewarn)
    else $error("nmi without prewarning");
  a_prewarn_holds: assert property (prewarn |=> prewarn)
    else $error("prewarning dropped");
  a_sysrst_holds: assert property (sys_reset_req |=> sys_reset_req)
    else $error("system reset request dropped");
  a_sysrst_after_warn: assert property (sys_reset_req |-> prewarn)
    else $error("system reset without prewarning");
  a_warn_before_rst: assert property (nmi |=> !sys_reset_req [*8])
    else $error("system reset too soon after trip");
endmodule
bind wwd_top wwd_top_asserts i_wwd_top_asserts (.ref_clk(ref_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .dbg_mode(dbg_mode), .nmi(nmi), .prewarn(prewarn),
  .sys_reset_req(sys_reset_req), .irq(irq));

// *** verilog/wwd_pkg.sv ***
package wwd_pkg;

  // register byte addresses on the plain register port
  localparam logic [7:0] WWD_ADDR_STATUS = 8'hB8;
  localparam logic [7:0] WWD_ADDR_MASK   = 8'hB9;
  localparam logic [7:0] WWD_ADDR_SVC    = 8'hBA;
  localparam logic [7:0] WWD_ADDR_CTRL   = 8'hBB;
  localparam logic [7:0] WWD_ADDR_RELOAD = 8'hBC;
  localparam logic [7:0] WWD_ADDR_WINDOW = 8'hBD;
  localparam logic [7:0] WWD_ADDR_CNT_LO = 8'hBE;
  localparam logic [7:0] WWD_ADDR_CNT_HI = 8'hBF;

  // control register fields
  localparam int WWD_CTRL_EN      = 0;
  localparam int WWD_CTRL_SLOW    = 1;
  localparam int WWD_CTRL_WIN_EN  = 2;
  localparam int WWD_CTRL_DBG_RUN = 3;
  localparam int WWD_CTRL_BITS    = 4;

  // status and mask fields
  localparam int WWD_ST_TIMEOUT = 0;
  localparam int WWD_ST_WINDOW  = 1;
  localparam int WWD_ST_BITS    = 2;

  // reset values
  localparam logic [7:0] WWD_RST_BYTE = 8'h00;
  localparam logic [WWD_CTRL_BITS-1:0] WWD_RST_CTRL = 4'h0;
  localparam logic [WWD_ST_BITS-1:0] WWD_RST_ST = 2'h0;

  // count-rate dividers of the peripheral clock
  localparam int WWD_DIV_FAST = 2;
  localparam int WWD_DIV_SLOW = 128;

  // byte maximum of the counter stages
  localparam logic [7:0] WWD_BYTE_MAX = 8'hFF;

  typedef enum logic [1:0] {
    WWD_RUN     = 2'b00,
    WWD_PREWARN = 2'b01,
    WWD_SYSRST  = 2'b10
  } wwd_state_e;

endpackage

// *** verilog/wwd_tick_div.sv ***
`timescale 1ns/100ps
module wwd_tick_div #(
  parameter int DIV_FAST = 2,
  parameter int DIV_SLOW = 128
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // control
  input  wire logic run,
  input  wire logic slow_sel,
  // one-cycle count enable
  output logic      tick
);

  localparam int W = $clog2(DIV_SLOW);
  localparam logic [W-1:0] FAST_LAST = W'(DIV_FAST - 1);
  localparam logic [W-1:0] SLOW_LAST = W'(DIV_SLOW - 1);
  localparam logic [W-1:0] ZERO      = '0;

  logic [W-1:0] div_r;
  logic [W-1:0] div_nxt;
  logic         tick_r;
  logic         tick_nxt;

  // prescaler holds still while counting is frozen
  always_comb begin
    div_nxt  = div_r;
    tick_nxt = 1'b0;
    if (run) begin
      if (div_r >= (slow_sel ? SLOW_LAST : FAST_LAST)) begin
        div_nxt  = ZERO;
        tick_nxt = 1'b1;
      end else begin
        div_nxt = div_r + W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      div_r  <= ZERO;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule

// *** verilog/wwd_top.sv ***
// Contract
// - counter is 16 bits, low byte carry advances the high byte
// - count rate is peripheral clock divided by 2 or by 128
// - each service access loads the high byte with the reload value; here only in the run state and not on a window violation
// - each service access clears the low byte; here only in the run state, where a window violation clears it through the trip
// - time-out raises NMI and prewarning, then a system reset
// - in debug mode counting is suspended by default, counter frozen
// - counter readable as low and high bytes at BE and BF, reset zero
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module wwd_top
  import wwd_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // debug mode pin from the on-chip debug logic
  input  wire logic       dbg_mode,
  // system outputs
  output logic            nmi,
  output logic            prewarn,
  output logic            sys_reset_req,
  output logic            irq
);

  // debug pin synchroniser
  logic dbg_meta_r;
  logic dbg_sync_r;

  // software state
  logic [WWD_CTRL_BITS-1:0] ctrl_r;
  logic [WWD_CTRL_BITS-1:0] ctrl_nxt;
  logic [7:0]               reload_r;
  logic [7:0]               reload_nxt;
  logic [7:0]               window_r;
  logic [7:0]               window_nxt;
  logic [WWD_ST_BITS-1:0]   mask_r;
  logic [WWD_ST_BITS-1:0]   mask_nxt;
  logic [WWD_ST_BITS-1:0]   status_r;
  logic [WWD_ST_BITS-1:0]   status_nxt;
  logic [7:0]               rdata_r;
  logic [7:0]               rdata_nxt;
  logic                     irq_r;
  logic                     irq_nxt;

  // counter and sequence state
  logic [7:0]  cnt_lo_r;
  logic [7:0]  cnt_lo_nxt;
  logic [7:0]  cnt_hi_r;
  logic [7:0]  cnt_hi_nxt;
  wwd_state_e  state_r;
  wwd_state_e  state_nxt;
  logic        nmi_r;
  logic        nmi_nxt;
  logic        prewarn_r;
  logic        prewarn_nxt;
  logic        sysrst_r;
  logic        sysrst_nxt;

  // decoded events
  logic frozen;
  logic counting;
  logic tick;
  logic svc_wr;
  logic expire;
  logic win_viol;
  logic trip;

  // two flops before the debug level is used anywhere
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dbg_meta_r <= 1'b0;
      dbg_sync_r <= 1'b0;
    end else begin
      dbg_meta_r <= dbg_mode;
      dbg_sync_r <= dbg_meta_r;
    end
  end

  // debug freezes the count unless software asked it to keep running
  assign frozen   = dbg_sync_r && !ctrl_r[WWD_CTRL_DBG_RUN];
  // after a trip the count keeps going to time the prewarning phase
  assign counting = !frozen && (ctrl_r[WWD_CTRL_EN] || (state_r != WWD_RUN));

  wwd_tick_div #(
    .DIV_FAST (WWD_DIV_FAST),
    .DIV_SLOW (WWD_DIV_SLOW)
  ) u_div (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .run      (counting),
    .slow_sel (ctrl_r[WWD_CTRL_SLOW]),
    .tick     (tick)
  );

  assign svc_wr   = reg_wr && (reg_addr == WWD_ADDR_SVC);
  assign expire   = tick && counting && (state_r == WWD_RUN) && ctrl_r[WWD_CTRL_EN]
                    && (cnt_lo_r == WWD_BYTE_MAX) && (cnt_hi_r == WWD_BYTE_MAX);
  // early service while the window check is on counts as a failure
  assign win_viol = svc_wr && (state_r == WWD_RUN) && ctrl_r[WWD_CTRL_EN]
                    && ctrl_r[WWD_CTRL_WIN_EN] && (cnt_hi_r < window_r);
  assign trip     = expire || win_viol;

  // counter and trip sequence
  always_comb begin
    cnt_lo_nxt  = cnt_lo_r;
    cnt_hi_nxt  = cnt_hi_r;
    state_nxt   = state_r;
    nmi_nxt     = 1'b0;
    prewarn_nxt = prewarn_r;
    sysrst_nxt  = sysrst_r;
    if (svc_wr && (state_r == WWD_RUN) && !win_viol) begin
      cnt_hi_nxt = reload_r;
      cnt_lo_nxt = WWD_RST_BYTE;
    end else if (tick && counting) begin
      cnt_lo_nxt = cnt_lo_r + 8'h01;
      if (cnt_lo_r == WWD_BYTE_MAX) begin
        cnt_hi_nxt = cnt_hi_r + 8'h01;
      end
    end
    case (state_r)
      WWD_RUN: begin
        if (trip) begin
          state_nxt   = WWD_PREWARN;
          nmi_nxt     = 1'b1;
          prewarn_nxt = 1'b1;
          cnt_lo_nxt  = WWD_RST_BYTE;
        end
      end
      WWD_PREWARN: begin
        // one more low-byte lap gives the handler time before the reset
        if (tick && counting && (cnt_lo_r == WWD_BYTE_MAX)) begin
          state_nxt  = WWD_SYSRST;
          sysrst_nxt = 1'b1;
        end
      end
      WWD_SYSRST: begin
        sysrst_nxt = 1'b1;
      end
      default: begin
        state_nxt = WWD_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_lo_r  <= WWD_RST_BYTE;
      cnt_hi_r  <= WWD_RST_BYTE;
      state_r   <= WWD_RUN;
      nmi_r     <= 1'b0;
      prewarn_r <= 1'b0;
      sysrst_r  <= 1'b0;
    end else begin
      cnt_lo_r  <= cnt_lo_nxt;
      cnt_hi_r  <= cnt_hi_nxt;
      state_r   <= state_nxt;
      nmi_r     <= nmi_nxt;
      prewarn_r <= prewarn_nxt;
      sysrst_r  <= sysrst_nxt;
    end
  end

  // register writes, sticky status and read mux
  always_comb begin
    ctrl_nxt   = ctrl_r;
    reload_nxt = reload_r;
    window_nxt = window_r;
    mask_nxt   = mask_r;
    status_nxt = status_r;
    rdata_nxt  = WWD_RST_BYTE;
    if (reg_wr) begin
      case (reg_addr)
        WWD_ADDR_CTRL:   ctrl_nxt   = reg_wdata[WWD_CTRL_BITS-1:0];
        WWD_ADDR_RELOAD: reload_nxt = reg_wdata;
        WWD_ADDR_WINDOW: window_nxt = reg_wdata;
        WWD_ADDR_MASK:   mask_nxt   = reg_wdata[WWD_ST_BITS-1:0];
        WWD_ADDR_STATUS: status_nxt = status_r & ~reg_wdata[WWD_ST_BITS-1:0];
        default:         ctrl_nxt   = ctrl_r;
      endcase
    end
    // a new event in the clearing cycle must not be lost, so set wins
    if (expire) begin
      status_nxt[WWD_ST_TIMEOUT] = 1'b1;
    end
    if (win_viol) begin
      status_nxt[WWD_ST_WINDOW] = 1'b1;
    end
    if (reg_rd) begin
      case (reg_addr)
        WWD_ADDR_STATUS: rdata_nxt = {{(8-WWD_ST_BITS){1'b0}}, status_r};
        WWD_ADDR_MASK:   rdata_nxt = {{(8-WWD_ST_BITS){1'b0}}, mask_r};
        WWD_ADDR_CTRL:   rdata_nxt = {{(8-WWD_CTRL_BITS){1'b0}}, ctrl_r};
        WWD_ADDR_RELOAD: rdata_nxt = reload_r;
        WWD_ADDR_WINDOW: rdata_nxt = window_r;
        WWD_ADDR_CNT_LO: rdata_nxt = cnt_lo_r;
        WWD_ADDR_CNT_HI: rdata_nxt = cnt_hi_r;
        default:         rdata_nxt = WWD_RST_BYTE;
      endcase
    end
    irq_nxt = |(status_nxt & mask_nxt);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_r   <= WWD_RST_CTRL;
      reload_r <= WWD_RST_BYTE;
      window_r <= WWD_RST_BYTE;
      mask_r   <= WWD_RST_ST;
      status_r <= WWD_RST_ST;
      rdata_r  <= WWD_RST_BYTE;
      irq_r    <= 1'b0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      reload_r <= reload_nxt;
      window_r <= window_nxt;
      mask_r   <= mask_nxt;
      status_r <= status_nxt;
      rdata_r  <= rdata_nxt;
      irq_r    <= irq_nxt;
    end
  end

  // all outputs straight from flops
  assign reg_rdata     = rdata_r;
  assign nmi           = nmi_r;
  assign prewarn       = prewarn_r;
  assign sys_reset_req = sysrst_r;
  assign irq           = irq_r;

endmodule
